// ### sim/tsw_line_model.sv
// Subscriber-side line model for the time slot switch port
`timescale 1ns/1ps
module tsw_line_model (
   input  wire logic [7:0] sp_in,
   input  wire logic [7:0] sp_oe_n_in,
   output logic      [3:0] du_out,
   output logic      [7:0] sp_level_out
);
   // Idle subscriber circuits answer all ones
   assign du_out = 4'hf;
   // Pull-up on each shared pin: a released pin reads high
   assign sp_level_out = sp_in | sp_oe_n_in;
endmodule : tsw_line_model

// ### sim/tsw_port_test.sv
// Self-checking bench of the time slot switch port
`timescale 1ns/1ps
module tsw_port_test;
   logic        ref_clk_in = 1'b0;
   logic        rst_n_in   = 1'b0;
   logic [7:0]  addr_in    = 8'h00;
   logic [31:0] wdata_in   = 32'h0;
   logic        wr_in      = 1'b0;
   logic        rd_in      = 1'b0;
   logic        rd_q       = 1'b0;
   logic        bck        = 1'b0;
   logic        bfp        = 1'b0;
   logic [14:0] rnd        = 15'h0;
   logic [1:0]  bq         = 2'h0;
   logic [31:0] rdata_out, e, eu, ex, exq[$];
   logic [3:0]  dd, dd_oe_n, du;
   logic [7:0]  sp_out, sp_oe_n, sp_lvl;
   logic        irq, busy, pdc_o, pdc_q, fs_o, pt_oe_n;
   int          num_errors = 0, checks_done = 0, cyc = 0, n, drv, ones, lit, spd, tog, fsh;
   tsw_port tsw_port_inst (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .addr_in(addr_in),
      .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
      .backplane_data_clock_in(bck), .backplane_frame_pulse_in(bfp),
      .port_data_clock_in(1'b0), .port_frame_sync_in(1'b0), .port_data_clock_out(pdc_o),
      .port_frame_sync_out(fs_o), .port_timing_oe_n_out(pt_oe_n), .downstream_data_out(dd),
      .downstream_data_oe_n_out(dd_oe_n), .upstream_data_in(du), .bidir_serial_port_out(sp_out),
      .bidir_serial_port_oe_n_out(sp_oe_n), .bidir_serial_port_in(sp_lvl),
      .bp_rx_valid_in(bq[0]), .bp_rx_slot_in(rnd[6:0]), .bp_rx_data_in(rnd[14:7]),
      .bp_tx_req_in(bq[1]), .bp_tx_slot_in(rnd[6:0]), .bp_tx_data_out(),
      .cmd_ind_change_irq_out(irq), .memory_access_busy_out(busy));
   tsw_line_model tsw_line_model_inst (.sp_in(sp_out), .sp_oe_n_in(sp_oe_n), .du_out(du),
      .sp_level_out(sp_lvl));
   always #20 ref_clk_in = ~ref_clk_in;
   // Backplane clock at half the reference rate; frame pulse every 256 cycles (64 bits)
   always @(posedge ref_clk_in) begin
      cyc  <= cyc + 1;
      bck  <= ~bck;
      bfp  <= (cyc % 256 == 0);
      rnd  <= 15'($urandom);
      bq   <= 2'($urandom);
      rd_q <= rd_in;
   end
   always @(negedge ref_clk_in) if (rd_q) begin
      ex = exq.pop_front();
      compare("read data", ex, rdata_out);
   end
   task automatic compare(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : compare
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk_in);
      addr_in  <= a;
      wdata_in <= d;
      wr_in    <= 1'b1;
      @(posedge ref_clk_in);
      wr_in <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      @(posedge ref_clk_in);
      exq.push_back(exp);
      addr_in <= a;
      rd_in   <= 1'b1;
      @(posedge ref_clk_in);
      rd_in <= 1'b0;
   endtask : rd
   // One full backplane frame of port pin activity
   task automatic watch();
      drv = 0;
      ones = 0;
      lit = 0;
      spd = 0;
      tog = 0;
      fsh = 0;
      @(negedge ref_clk_in);
      pdc_q = pdc_o;
      repeat (256) begin
         @(negedge ref_clk_in);
         if (dd_oe_n[0] === 1'b0) drv++;
         if (dd_oe_n[0] === 1'b0 && dd[0] === 1'b1) ones++;
         if (dd_oe_n !== 4'hf || sp_oe_n !== 8'hff) lit++;
         if (sp_oe_n[0] === 1'b0) spd++;
         if (fs_o === 1'b1) fsh++;
         if (pdc_o !== pdc_q) tog++;
         pdc_q = pdc_o;
      end
   endtask : watch
   task automatic close_out();
      $display("checks %0d mismatches %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : close_out
   initial begin
      #(40 * 20000);
      num_errors++;
      close_out();
   end
   initial begin
      void'($urandom(32'h3c01ba8c));
      repeat (20) @(posedge ref_clk_in);
      rst_n_in <= 1'b1;
      rd(tsw_pkg::REG_MODE, {24'h0, tsw_pkg::MODE_RST});
      rd(tsw_pkg::REG_SLOTS, {24'h0, tsw_pkg::SLOTS_RST});
      rd(tsw_pkg::REG_IDLE, {24'h0, tsw_pkg::IDLE_RST});
      rd(8'h20, 32'h0);
      watch();
      compare("standby pins", 0, lit);
      compare("timing pins", 0, pt_oe_n);
      $display("test reset done");
      wr(tsw_pkg::REG_CMADR, 32'h07);
      wr(tsw_pkg::REG_CMDAT, {12'h0, tsw_pkg::C_SW8, 16'h1234});
      wr(tsw_pkg::REG_STATUS, 32'h1);
      n = 0;
      repeat (300) begin
         @(negedge ref_clk_in);
         if (busy === 1'b1) n++;
      end
      compare("busy cycles", 256, n);
      wr(tsw_pkg::REG_CMADR, 32'h07);
      rd(tsw_pkg::REG_CMDAT, {12'h0, tsw_pkg::C_UNAS, 16'h1234});
      $display("test memory reset done");
      wr(tsw_pkg::REG_CMADR, 32'h03);
      e = {12'h0, tsw_pkg::C_SW8, 1'b0, rnd};
      wr(tsw_pkg::REG_CMDAT, e);
      eu = {17'h0, ~rnd};
      wr(tsw_pkg::REG_CMADR, 32'h83);
      wr(tsw_pkg::REG_CMDAT, eu);
      rd(tsw_pkg::REG_CMDAT, eu);
      wr(tsw_pkg::REG_CMADR, 32'h03);
      rd(tsw_pkg::REG_CMDAT, e);
      $display("test memory program done");
      wr(tsw_pkg::REG_SLOTS, 32'h2);
      wr(tsw_pkg::REG_CMADR, 32'h82);
      wr(tsw_pkg::REG_CMDAT, {12'h0, tsw_pkg::C_UP, 16'h0});
      repeat (300) @(posedge ref_clk_in);
      compare("irq", 0, irq);
      rd(tsw_pkg::REG_CMDAT, {12'h0, tsw_pkg::C_UP, 16'h00ff});
      // Pre-processed pair starts on an even slot
      wr(tsw_pkg::REG_CMADR, 32'h80);
      wr(tsw_pkg::REG_CMDAT, {12'h0, tsw_pkg::C_MON, 16'h0});
      wr(tsw_pkg::REG_CMADR, 32'h81);
      wr(tsw_pkg::REG_CMDAT, {12'h0, tsw_pkg::C_CI, 16'h0});
      repeat (300) @(posedge ref_clk_in);
      compare("irq", 1, irq);
      rd(tsw_pkg::REG_CHG, 32'h81);
      rd(tsw_pkg::REG_CHG, 32'h0);
      $display("test upstream slots done");
      wr(tsw_pkg::REG_MODE, 32'h0);
      watch();
      compare("float drive", 0, drv);
      compare("data clock toggles", 128, tog);
      compare("frame sync high", 128, fsh);
      wr(tsw_pkg::REG_CMADR, 32'h00);
      wr(tsw_pkg::REG_CMDAT, {12'h0, tsw_pkg::C_UNAS, 16'h8000});
      watch();
      compare("idle driven", 1, drv > 0);
      compare("idle ones", drv, ones);
      wr(tsw_pkg::REG_MODE, 32'h4);
      watch();
      compare("standby pins", 0, lit);
      $display("test downstream pins done");
      // Line data frame: port 0 drives slots 0 and 3, listens in slots 4 to 7
      wr(tsw_pkg::REG_MODE, 32'h3);
      repeat (256) @(posedge ref_clk_in);
      watch();
      compare("line data driven", 64, spd);
      $display("test line data frame done");
      close_out();
   end
endmodule : tsw_port_test

// ### verilog/tsw_pkg.sv
// Shared constants and types of the time slot switch port
package tsw_pkg;
   localparam int NLOC      = 128;
   localparam int NBIDIR    = 8;
   localparam int NDUP      = 4;
   localparam int SLD_SLOTS = 8;
   localparam int SLD_OUT   = 4;
   localparam int MIN_SLOTS = 2;
   localparam int CHG_DEPTH = 8;
   localparam logic [7:0] CM_RESET_LAST = 8'hff;  // 256 cycles
   // ---------------------------------------------------------------
   // Register word addresses
   // ---------------------------------------------------------------
   localparam logic [7:0] REG_MODE   = 8'h00;
   localparam logic [7:0] REG_TIMING = 8'h01;
   localparam logic [7:0] REG_SLOTS  = 8'h02;
   localparam logic [7:0] REG_SUBPOS = 8'h03;
   localparam logic [7:0] REG_IDLE   = 8'h04;
   localparam logic [7:0] REG_CMADR  = 8'h05;
   localparam logic [7:0] REG_CMDAT  = 8'h06;
   localparam logic [7:0] REG_STATUS = 8'h07;
   localparam logic [7:0] REG_CHG    = 8'h08;
   localparam logic [7:0] REG_SYNC0  = 8'h0a;
   localparam logic [7:0] REG_SDAT0  = 8'h0c;
   // Mode register bits
   localparam int M_BIDIR = 0;
   localparam int M_SLD   = 1;
   localparam int M_STBY  = 2;
   localparam int M_IDLE  = 3;
   localparam int M_EXT   = 4;
   localparam int M_DBL   = 5;
   localparam int M_WAVE  = 6;
   // Status bits; bit 0 written starts the control memory reset
   localparam int S_BUSY  = 0;
   localparam int S_IRQ   = 1;
   localparam int S_FIFO  = 2;
   localparam int SY_EN   = 15;
   localparam int SY_DST  = 8;
   localparam logic [7:0] MODE_RST  = 8'h04;
   localparam logic [7:0] SLOTS_RST = 8'h20;
   localparam logic [7:0] IDLE_RST  = 8'hff;
   // Control memory codes
   localparam logic [3:0] C_UNAS = 4'h0;
   localparam logic [3:0] C_SW8  = 4'h1;
   localparam logic [3:0] C_SW4  = 4'h2;
   localparam logic [3:0] C_SW2  = 4'h3;
   localparam logic [3:0] C_UP   = 4'h4;
   localparam logic [3:0] C_MON  = 4'h8;
   localparam logic [3:0] C_CI   = 4'hb;
   localparam logic [3:0] C_SIG6 = 4'hc;
   localparam logic [3:0] C_SIG8 = 4'hd;
   localparam logic [7:0] MASK_CI   = 8'h3c;
   localparam logic [7:0] MASK_SIG6 = 8'hfc;
   typedef struct packed {
      logic [3:0] code;
      logic       idle_drv;
      logic [6:0] bp_slot;
      logic [7:0] data;
   } tsw_cm_t;
endpackage : tsw_pkg

// ### verilog/tsw_port.sv
// Time slot switch with configurable subscriber-side serial port
`timescale 1ns/1ps
module tsw_port (
   input  wire logic        ref_clk_in,
   input  wire logic        rst_n_in,
   input  wire logic [7:0]  addr_in,
   input  wire logic [31:0] wdata_in,
   input  wire logic        wr_in,
   input  wire logic        rd_in,
   output logic      [31:0] rdata_out,
   input  wire logic        backplane_data_clock_in,
   input  wire logic        backplane_frame_pulse_in,
   input  wire logic        port_data_clock_in,
   input  wire logic        port_frame_sync_in,
   output logic             port_data_clock_out,
   output logic             port_frame_sync_out,
   output logic             port_timing_oe_n_out,
   output logic      [3:0]  downstream_data_out,
   output logic      [3:0]  downstream_data_oe_n_out,
   input  wire logic [3:0]  upstream_data_in,
   output logic      [7:0]  bidir_serial_port_out,
   output logic      [7:0]  bidir_serial_port_oe_n_out,
   input  wire logic [7:0]  bidir_serial_port_in,
   input  wire logic        bp_rx_valid_in,
   input  wire logic [6:0]  bp_rx_slot_in,
   input  wire logic [7:0]  bp_rx_data_in,
   input  wire logic        bp_tx_req_in,
   input  wire logic [6:0]  bp_tx_slot_in,
   output logic      [7:0]  bp_tx_data_out,
   output logic             cmd_ind_change_irq_out,
   output logic             memory_access_busy_out
);
   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [7:0]                        mode;
      logic [7:0]                        prescale;
      logic [7:0]                        slots;
      logic [15:0]                       subpos;
      logic [7:0]                        idle_val;
      logic [7:0]                        cm_adr;
      tsw_pkg::tsw_cm_t [127:0]          cm_dn;
      tsw_pkg::tsw_cm_t [127:0]          cm_up;
      logic [127:0][7:0]                 bp_dn;
      logic [127:0][7:0]                 bp_up;
      logic [7:0]                        pre_cnt;
      logic [1:0]                        phase;
      logic [2:0]                        bit_cnt;
      logic [7:0]                        slot;
      logic                              dclk;
      logic                              fsync;
      logic                              clk_d;
      logic                              fp_d;
      logic [7:0][7:0]                   sh_out;
      logic [7:0][7:0]                   sh_oe;
      logic [7:0][7:0]                   sh_in;
      logic                              busy;
      logic [7:0]                        rst_cnt;
      logic                              irq;
      logic [7:0][7:0]                   chg;
      logic [3:0]                        wp;
      logic [3:0]                        rp;
      logic [1:0][15:0]                  sync_cfg;
      logic [1:0][7:0]                   sync_dat;
      logic [31:0]                       rdata;
      logic [7:0]                        bp_tx;
   } tsw_state_t;

   tsw_state_t s;
   tsw_state_t n;
   logic       ref_tick;
   logic       push_any;

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb begin
      logic             clk_src, fp_src, clk_edge, fp_edge, bit_tick, load, eos;
      logic [7:0]       eff, nslot, rx, mask, byte_v, idle_mask;
      logic [9:0]       loc, nloc;
      logic             act, is_in, drv;
      logic [1:0]       pos;
      tsw_pkg::tsw_cm_t e;
      n = s;
      push_any = 1'b0;
      bit_tick = 1'b0;
      load = 1'b0;
      eos = 1'b0;
      nslot = 8'h00;
      eff = 8'h00;
      rx = 8'h00;
      mask = 8'h00;
      byte_v = 8'h00;
      idle_mask = 8'h00;
      loc = 10'h000;
      nloc = 10'h000;
      act = 1'b0;
      is_in = 1'b0;
      drv = 1'b0;
      pos = 2'h0;
      e = '0;
      clk_src = s.mode[tsw_pkg::M_EXT] ? port_data_clock_in : backplane_data_clock_in;
      fp_src = s.mode[tsw_pkg::M_EXT] ? port_frame_sync_in : backplane_frame_pulse_in;
      clk_edge = clk_src & ~s.clk_d;
      fp_edge = fp_src & ~s.fp_d;
      n.clk_d = clk_src;
      n.fp_d = fp_src;
      ref_tick = clk_edge && (s.pre_cnt == s.prescale);
      if (clk_edge) begin
         n.pre_cnt = ref_tick ? 8'h00 : s.pre_cnt + 8'h01;
      end
      bit_tick = ref_tick && (s.phase == (s.mode[tsw_pkg::M_DBL] ? 2'h3 : 2'h1));
      if (ref_tick) begin
         n.phase = bit_tick ? 2'h0 : s.phase + 2'h1;
         n.dclk = ~s.dclk;
      end
      if (s.mode[tsw_pkg::M_SLD]) begin
         eff = 8'(tsw_pkg::SLD_SLOTS);
      end else if (s.slots < 8'(tsw_pkg::MIN_SLOTS)) begin
         eff = 8'(tsw_pkg::MIN_SLOTS);
      end else if (s.slots > 8'(tsw_pkg::NLOC)) begin
         eff = 8'(tsw_pkg::NLOC);
      end else begin
         eff = s.slots;
      end
      if (bit_tick) begin
         n.bit_cnt = s.bit_cnt + 3'h1;
         if (s.bit_cnt == 3'h7) begin
            eos = 1'b1;
            load = 1'b1;
            nslot = (s.slot >= eff - 8'h01) ? 8'h00 : s.slot + 8'h01;
         end
      end
      // A frame edge on the last bit still lets that slot finish upstream
      if (fp_edge) begin
         load = 1'b1;
         nslot = 8'h00;
         n.bit_cnt = 3'h0;
         n.phase = 2'h0;
         n.pre_cnt = 8'h00;
      end
      // Bus writes first so that hardware updates below win
      if (wr_in) begin
         unique case (addr_in)
            tsw_pkg::REG_MODE:   n.mode = wdata_in[7:0];
            tsw_pkg::REG_TIMING: n.prescale = wdata_in[7:0];
            tsw_pkg::REG_SLOTS:  n.slots = wdata_in[7:0];
            tsw_pkg::REG_SUBPOS: n.subpos = wdata_in[15:0];
            tsw_pkg::REG_IDLE:   n.idle_val = wdata_in[7:0];
            tsw_pkg::REG_CMADR:  n.cm_adr = wdata_in[7:0];
            tsw_pkg::REG_CMDAT: begin
               if (!s.busy && s.cm_adr[7]) n.cm_up[s.cm_adr[6:0]] = wdata_in[19:0];
               if (!s.busy && !s.cm_adr[7]) n.cm_dn[s.cm_adr[6:0]] = wdata_in[19:0];
            end
            tsw_pkg::REG_STATUS: begin
               if (wdata_in[tsw_pkg::S_BUSY] && !s.busy) begin
                  n.busy = 1'b1;
                  n.rst_cnt = 8'h00;
               end
               if (wdata_in[tsw_pkg::S_IRQ]) n.irq = 1'b0;
            end
            tsw_pkg::REG_SYNC0:        n.sync_cfg[0] = wdata_in[15:0];
            tsw_pkg::REG_SYNC0 + 8'h1: n.sync_cfg[1] = wdata_in[15:0];
            tsw_pkg::REG_SDAT0:        n.sync_dat[0] = wdata_in[7:0];
            tsw_pkg::REG_SDAT0 + 8'h1: n.sync_dat[1] = wdata_in[7:0];
            default: ;
         endcase
      end
      // Control memory reset: one location per cycle, downstream then upstream
      if (s.busy) begin
         if (s.rst_cnt[7]) n.cm_up[s.rst_cnt[6:0]].code = tsw_pkg::C_UNAS;
         else n.cm_dn[s.rst_cnt[6:0]].code = tsw_pkg::C_UNAS;
         n.rst_cnt = s.rst_cnt + 8'h01;
         if (s.rst_cnt == tsw_pkg::CM_RESET_LAST) n.busy = 1'b0;
      end
      if (bp_rx_valid_in) n.bp_dn[bp_rx_slot_in] = bp_rx_data_in;
      n.bp_tx = bp_tx_req_in ? s.bp_up[bp_tx_slot_in] : 8'h00;
      if (s.mode[tsw_pkg::M_WAVE] && bit_tick) n.fsync = 1'b0;
      if (load) begin
         n.slot = nslot;
         n.fsync = (nslot == 8'h00);
      end
      for (int p = 0; p < tsw_pkg::NBIDIR; p++) begin
         act = s.mode[tsw_pkg::M_BIDIR] || (p < tsw_pkg::NDUP);
         pos = s.subpos[2*p +: 2];
         loc = 10'(p) * 10'(eff) + 10'(s.slot);
         rx = {s.sh_in[p][6:0], s.mode[tsw_pkg::M_BIDIR] ? bidir_serial_port_in[p] :
               upstream_data_in[p[1:0]]};
         if (bit_tick) begin
            n.sh_in[p] = rx;
            n.sh_out[p] = {s.sh_out[p][6:0], 1'b0};
            n.sh_oe[p] = {s.sh_oe[p][6:0], 1'b0};
         end
         if (!s.mode[tsw_pkg::M_BIDIR]) is_in = 1'b1;
         else if (s.mode[tsw_pkg::M_SLD]) is_in = s.slot >= 8'(tsw_pkg::SLD_OUT);
         else is_in = s.cm_dn[loc[6:0]].code == tsw_pkg::C_UNAS;
         // Upstream handling of the finished slot
         if (eos && act && is_in && loc < 10'(tsw_pkg::NLOC)) begin
            e = s.cm_up[loc[6:0]];
            mask = (e.code == tsw_pkg::C_SW4) ? (8'hf0 >> {pos[1], 2'h0}) :
                   (e.code == tsw_pkg::C_SW2) ? (8'hc0 >> {pos, 1'b0}) : 8'hff;
            unique case (e.code)
               tsw_pkg::C_SW8, tsw_pkg::C_SW4, tsw_pkg::C_SW2:
                  n.bp_up[e.bp_slot] = (n.bp_up[e.bp_slot] & ~mask) | (rx & mask);
               tsw_pkg::C_UP: n.cm_up[loc[6:0]].data = rx;
               tsw_pkg::C_CI: begin
                  if ((rx & tsw_pkg::MASK_CI) != (e.data & tsw_pkg::MASK_CI)) begin
                     n.cm_up[loc[6:0]].data = rx;
                     push_any = 1'b1;
                     n.irq = 1'b1;
                     if (n.wp - s.rp != 4'(tsw_pkg::CHG_DEPTH)) begin
                        n.chg[n.wp[2:0]] = {1'b1, loc[6:0]};
                        n.wp = n.wp + 4'h1;
                     end
                  end
               end
               tsw_pkg::C_SIG6, tsw_pkg::C_SIG8: begin
                  mask = (e.code == tsw_pkg::C_SIG6) ? tsw_pkg::MASK_SIG6 : 8'hff;
                  // Last look: new sample equal to last frame's, yet unlike the stable one
                  if (((rx ^ s.cm_up[loc[6:0] - 7'h1].data) & mask) == 8'h00 &&
                      ((rx ^ e.data) & mask) != 8'h00) begin
                     n.cm_up[loc[6:0]].data = rx;
                     push_any = 1'b1;
                     n.irq = 1'b1;
                     if (n.wp - s.rp != 4'(tsw_pkg::CHG_DEPTH)) begin
                        n.chg[n.wp[2:0]] = {1'b1, loc[6:0]};
                        n.wp = n.wp + 4'h1;
                     end
                  end
                  n.cm_up[loc[6:0] - 7'h1].data = rx;
               end
               default: ;
            endcase
            for (int c = 0; c < 2; c++) begin
               if (s.sync_cfg[c][tsw_pkg::SY_EN] && s.sync_cfg[c][6:0] == loc[6:0])
                  n.sync_dat[c] = rx;
            end
         end
         // Downstream load of the next slot
         if (load) begin
            nloc = 10'(p) * 10'(eff) + 10'(nslot);
            e = s.cm_dn[nloc[6:0]];
            if (!s.mode[tsw_pkg::M_BIDIR]) drv = 1'b1;
            else if (s.mode[tsw_pkg::M_SLD]) drv = nslot < 8'(tsw_pkg::SLD_OUT);
            else drv = e.code != tsw_pkg::C_UNAS || e.idle_drv;
            drv = drv && act && nloc < 10'(tsw_pkg::NLOC);
            byte_v = e.data;
            mask = 8'hff;
            unique case (e.code)
               tsw_pkg::C_UNAS: begin
                  byte_v = s.idle_val;
                  mask = {8{e.idle_drv}};
               end
               tsw_pkg::C_SW8: byte_v = s.bp_dn[e.bp_slot];
               tsw_pkg::C_SW4: begin
                  byte_v = s.bp_dn[e.bp_slot];
                  mask = 8'hf0 >> {pos[1], 2'h0};
               end
               tsw_pkg::C_SW2: begin
                  byte_v = s.bp_dn[e.bp_slot];
                  mask = 8'hc0 >> {pos, 1'b0};
               end
               tsw_pkg::C_UP: ;
               tsw_pkg::C_MON: mask = 8'h00;
               tsw_pkg::C_CI: mask = tsw_pkg::MASK_CI;
               tsw_pkg::C_SIG6: mask = tsw_pkg::MASK_SIG6;
               default: ;
            endcase
            for (int c = 0; c < 2; c++) begin
               if (s.sync_cfg[c][tsw_pkg::SY_EN] && s.sync_cfg[c][14:8] == nloc[6:0]) begin
                  byte_v = n.sync_dat[c];
                  mask = 8'hff;
               end
            end
            // Unassigned slots without idle drive float entirely, sub-slot gaps follow select
            idle_mask = (e.code == tsw_pkg::C_UNAS || !s.mode[tsw_pkg::M_IDLE]) ? 8'h00 : ~mask;
            n.sh_out[p] = (byte_v & mask) | idle_mask;
            n.sh_oe[p] = drv ? (mask | idle_mask) : 8'h00;
         end
      end
      n.rdata = 32'h0000_0000;
      if (rd_in) begin
         unique case (addr_in)
            tsw_pkg::REG_MODE:   n.rdata = {24'h0, s.mode};
            tsw_pkg::REG_TIMING: n.rdata = {24'h0, s.prescale};
            tsw_pkg::REG_SLOTS:  n.rdata = {24'h0, s.slots};
            tsw_pkg::REG_SUBPOS: n.rdata = {16'h0, s.subpos};
            tsw_pkg::REG_IDLE:   n.rdata = {24'h0, s.idle_val};
            tsw_pkg::REG_CMADR:  n.rdata = {24'h0, s.cm_adr};
            tsw_pkg::REG_CMDAT:  n.rdata = {12'h0, s.cm_adr[7] ? s.cm_up[s.cm_adr[6:0]] :
                                            s.cm_dn[s.cm_adr[6:0]]};
            tsw_pkg::REG_STATUS: n.rdata = {29'h0, s.wp != s.rp, s.irq, s.busy};
            tsw_pkg::REG_CHG: begin
               if (s.wp != s.rp) begin
                  n.rdata = {24'h0, s.chg[s.rp[2:0]]};
                  n.rp = s.rp + 4'h1;
               end
            end
            tsw_pkg::REG_SYNC0:        n.rdata = {16'h0, s.sync_cfg[0]};
            tsw_pkg::REG_SYNC0 + 8'h1: n.rdata = {16'h0, s.sync_cfg[1]};
            tsw_pkg::REG_SDAT0:        n.rdata = {24'h0, s.sync_dat[0]};
            tsw_pkg::REG_SDAT0 + 8'h1: n.rdata = {24'h0, s.sync_dat[1]};
            default: ;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   // Memories hold no reset value in the real part either; zero is simply safe
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         s <= '0;
         s.mode <= tsw_pkg::MODE_RST;
         s.slots <= tsw_pkg::SLOTS_RST;
         s.idle_val <= tsw_pkg::IDLE_RST;
      end else begin
         s <= n;
      end
   end

   always_comb begin
      for (int p = 0; p < tsw_pkg::NBIDIR; p++) begin
         bidir_serial_port_out[p] = s.sh_out[p][7];
         bidir_serial_port_oe_n_out[p] = ~(s.sh_oe[p][7] & s.mode[tsw_pkg::M_BIDIR] &
                                           ~s.mode[tsw_pkg::M_STBY]);
      end
      for (int p = 0; p < tsw_pkg::NDUP; p++) begin
         downstream_data_out[p] = s.sh_out[p][7];
         downstream_data_oe_n_out[p] = ~(s.sh_oe[p][7] & ~s.mode[tsw_pkg::M_BIDIR] &
                                         ~s.mode[tsw_pkg::M_STBY]);
      end
   end
   assign port_data_clock_out = s.dclk & ~s.mode[tsw_pkg::M_EXT];
   assign port_frame_sync_out = s.fsync & ~s.mode[tsw_pkg::M_EXT];
   assign port_timing_oe_n_out = s.mode[tsw_pkg::M_EXT];
   assign rdata_out = s.rdata;
   assign bp_tx_data_out = s.bp_tx;
   assign cmd_ind_change_irq_out = s.irq;
   assign memory_access_busy_out = s.busy;

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (!rst_n_in);
   AST_STANDBY_FLOAT: assert property (s.mode[tsw_pkg::M_STBY] |->
      &downstream_data_oe_n_out && &bidir_serial_port_oe_n_out) else $error("standby drives");
   AST_DUPLEX_NO_BIDIR: assert property (!s.mode[tsw_pkg::M_BIDIR] |->
      &bidir_serial_port_oe_n_out) else $error("bidir driven in duplex mode");
   AST_SLD_INPUT_SLOTS: assert property (s.mode[tsw_pkg::M_SLD] && s.slot >= 8'h04 &&
      s.bit_cnt != 3'h0 |-> &bidir_serial_port_oe_n_out) else $error("sld input slot driven");
   AST_RESET_START: assert property ($rose(s.busy) |-> s.rst_cnt == 8'h00)
      else $error("reset count not cleared");
   AST_RESET_END: assert property (s.busy && s.rst_cnt == 8'hff |=>
      !s.busy ##1 (!s.busy || s.rst_cnt == 8'h00)) else $error("reset length wrong");
   AST_RESET_CLEARS: assert property (s.busy && s.rst_cnt == 8'h00 |=>
      s.cm_dn[0].code == tsw_pkg::C_UNAS) else $error("location not cleared");
   AST_CHANGE_IRQ: assert property (push_any |=> cmd_ind_change_irq_out)
      else $error("change without irq");
   AST_SLOT_RANGE: assert property (s.slot < 8'(tsw_pkg::NLOC))
      else $error("slot counter out of range");
   AST_DCLK_TICK: assert property ($changed(s.dclk) |-> $past(ref_tick))
      else $error("data clock toggled off tick");
   AST_BP_TX: assert property (bp_tx_req_in |=>
      bp_tx_data_out == $past(s.bp_up[bp_tx_slot_in])) else $error("backplane read data wrong");
   COV_RESET: cover property ($fell(s.busy));
   COV_CHANGE: cover property (push_any);
   COV_WRAP: cover property (s.slot != 8'h00 ##1 s.slot == 8'h00);
endmodule : tsw_port
